//--- verilog/sbsp_map.vh
// constants for the synchronous burst sram port
`ifndef SBSP_MAP_VH
`define SBSP_MAP_VH
`define SBSP_ADDR_W     18
`define SBSP_LANES      4
`define SBSP_LANE_W     9
`define SBSP_BURST_W    2
`define SBSP_BURST_RST  2'h0
`endif

//--- verilog/sbsp_mem.v
// byte-lane memory array with registered read data
`timescale 1ns/1ps
module sbsp_mem #(
  parameter ADDR_W = 18,
  parameter LANES  = 4,
  parameter LANE_W = 9
) (
  // clock
  input  wire                      mclk,
  // write side
  input  wire                      wrEn,
  input  wire [LANES-1:0]          laneEn,
  input  wire [ADDR_W-1:0]         addr,
  input  wire [LANES*LANE_W-1:0]   wrData,
  // read side
  output reg  [LANES*LANE_W-1:0]   rdData
);
  reg [LANES*LANE_W-1:0] cells [0:(1<<ADDR_W)-1];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : gLane
      always @(posedge mclk) begin
        if (wrEn && laneEn[g]) begin
          cells[addr][g*LANE_W +: LANE_W] <= wrData[g*LANE_W +: LANE_W];
        end
      end
    end
  endgenerate
  always @(posedge mclk) begin
    rdData <= cells[addr];
  end
endmodule

//--- verilog/sbsp_port.v
// synchronous pipelined burst sram port: control, burst counter, array
`timescale 1ns/1ps
`include "sbsp_map.vh"
module sbsp_port #(
  parameter ADDR_W    = `SBSP_ADDR_W,
  parameter LANES     = `SBSP_LANES,
  parameter LANE_W    = `SBSP_LANE_W,
  parameter HAS_DEPTH = 1
) (
  // clock and reset
  input  wire                      mclk,
  input  wire                      resetn,
  // address and strobes
  input  wire [ADDR_W-1:0]         addrIn,
  input  wire                      proc_addr_strobe_n,
  input  wire                      ctrl_addr_strobe_n,
  input  wire                      burst_advance_n,
  // chip selects
  input  wire                      chip_sel_primary_n,
  input  wire                      chip_sel_high,
  input  wire                      chip_sel_depth_n,
  // write controls
  input  wire [LANES-1:0]          byte_lane_write_sel_n,
  input  wire                      byte_write_qualify_n,
  input  wire                      all_bytes_write_n,
  // output enable
  input  wire                      output_en_n,
  // data pins
  input  wire [LANES*LANE_W-1:0]   dataIn,
  output wire [LANES*LANE_W-1:0]   dataOut,
  output wire [LANES*LANE_W-1:0]   dataOe
);
  reg  [ADDR_W-1:0]       addrReg;
  reg  [`SBSP_BURST_W-1:0] burstCnt;
  reg                     selected;
  reg                     readFirst;
  reg                     wrPend;
  reg  [LANES-1:0]        wrLanes;
  reg  [LANES*LANE_W-1:0] wrData;
  wire [LANES*LANE_W-1:0] rdData;
  wire                    depthOk;
  wire                    chipOn;
  wire                    procGo;
  wire                    ctrlGo;
  wire                    capture;
  wire                    deselect;
  wire                    isWrite;
  wire [LANES-1:0]        next_lanes;
  wire [ADDR_W-1:0]       curAddr;

  assign depthOk = HAS_DEPTH ? ~chip_sel_depth_n : 1'b1;
  assign chipOn  = ~chip_sel_primary_n & chip_sel_high & depthOk;
  // processor strobe only counts with primary select low
  assign procGo  = ~proc_addr_strobe_n & ~chip_sel_primary_n;
  // an ignored processor strobe must not hide the controller strobe
  assign ctrlGo  = ~procGo & ~ctrl_addr_strobe_n;
  assign capture = (procGo | ctrlGo) & chipOn;
  assign deselect = (procGo | ctrlGo) & ~chipOn;
  // lane write mask: global write beats byte controls
  assign next_lanes = ~all_bytes_write_n ? {LANES{1'b1}} :
                      (~byte_write_qualify_n ? ~byte_lane_write_sel_n
                                             : {LANES{1'b0}});
  // a processor strobe that selects the chip always starts a read cycle
  assign isWrite = ~procGo & (|next_lanes);
  assign curAddr = {addrReg[ADDR_W-1:`SBSP_BURST_W], burstCnt};

  always @(posedge mclk) begin
    if (!resetn) begin
      addrReg   <= {ADDR_W{1'b0}};
      burstCnt  <= `SBSP_BURST_RST;
      selected  <= 1'b0;
      readFirst <= 1'b0;
      wrPend    <= 1'b0;
      wrLanes   <= {LANES{1'b0}};
      wrData    <= {LANES*LANE_W{1'b0}};
    end else begin
      readFirst <= 1'b0;
      wrPend    <= 1'b0;
      if (capture) begin
        addrReg  <= addrIn;
        burstCnt <= addrIn[`SBSP_BURST_W-1:0];
        selected <= 1'b1;
        readFirst <= ~selected & ~isWrite;
      end else if (deselect) begin
        selected <= 1'b0;
      end else if (selected && !burst_advance_n) begin
        burstCnt <= burstCnt + 1'b1;
      end
      // writes sampled in a selected cycle, performed next clock
      if ((capture || selected) && !deselect && isWrite) begin
        wrPend  <= 1'b1;
        wrLanes <= next_lanes;
        wrData  <= dataIn;
      end
    end
  end

  // array read is registered: data follows capture by one clock
  sbsp_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) uMem (
    .mclk   (mclk),
    .wrEn   (wrPend),
    .laneEn (wrLanes),
    .addr   (curAddr),
    .wrData (wrData),
    .rdData (rdData)
  );

  assign dataOut = rdData;
  // enable is combinational on the pin so it acts without the clock
  assign dataOe = {LANES*LANE_W{~output_en_n & ~readFirst}};
endmodule

//--- bench/sbsp_ctrl_model.sv
// controller-side model of the shared data pins
`timescale 1ns/1ps
module sbsp_ctrl_model (
  input  wire        mclk,
  input  wire [35:0] wrData,
  input  wire [35:0] dataOe,
  output reg  [35:0] dataIn
);
  reg [35:0] last = 36'h0;
  always @(posedge mclk) last <= dataIn;
  // floating pins show a changing pattern, not a held value
  always @* dataIn = dataOe[0] ? ~last : wrData;
endmodule

//--- bench/sbsp_port_monitor.sv
// pin-level assertions for the burst sram port
`timescale 1ns/1ps
module sbsp_port_monitor #(parameter W = 36) (
  input wire mclk, resetn, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
  input wire chip_sel_primary_n, chip_sel_high, chip_sel_depth_n, output_en_n,
  input wire byte_write_qualify_n, all_bytes_write_n,
  input wire [W-1:0] dataOut, dataOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire on = !chip_sel_primary_n && chip_sel_high && !chip_sel_depth_n;
  wire rd = !proc_addr_strobe_n && on;
  wire dsl = proc_addr_strobe_n && !ctrl_addr_strobe_n && !on;
  wire nos = proc_addr_strobe_n && ctrl_addr_strobe_n;
  // an ignored processor strobe must look like no request at all
  wire calm = (proc_addr_strobe_n || chip_sel_primary_n) && ctrl_addr_strobe_n
    && burst_advance_n && byte_write_qualify_n && all_bytes_write_n;
  property p_off; output_en_n |-> dataOe == 0; endproperty
  a_off: assert property (p_off) else $error("pins driven");
  property p_on; !output_en_n && $past(nos) |-> &dataOe; endproperty
  a_on: assert property (p_on) else $error("pins not driven");
  property p_pr; dsl && chip_sel_primary_n ##1 rd |=> dataOe == 0; endproperty
  a_pr: assert property (p_pr) else $error("no mask");
  property p_hi; dsl && !chip_sel_high ##1 rd |=> dataOe == 0; endproperty
  a_hi: assert property (p_hi) else $error("no mask");
  property p_dp; dsl && chip_sel_depth_n ##1 rd |=> dataOe == 0; endproperty
  a_dp: assert property (p_dp) else $error("no mask");
  property p_both; dsl ##1 (rd && !byte_write_qualify_n) |=> dataOe == 0; endproperty
  a_both: assert property (p_both) else $error("not a read");
  property p_hold; calm [*3] |=> $stable(dataOut); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_rr; rd ##1 rd |=> output_en_n || &dataOe; endproperty
  a_rr: assert property (p_rr) else $error("bad mask");
endmodule
bind sbsp_port sbsp_port_monitor #(.W(LANES*LANE_W)) i_mon (.*);

//--- bench/sbsp_port_tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module sbsp_port_tb;
  reg mclk = 0, resetn = 0, output_en_n = 1;
  reg proc_addr_strobe_n = 1, ctrl_addr_strobe_n = 1, burst_advance_n = 1;
  reg chip_sel_primary_n = 1, chip_sel_high = 0, chip_sel_depth_n = 1;
  reg byte_write_qualify_n = 1, all_bytes_write_n = 1;
  reg [3:0] byte_lane_write_sel_n = 4'hF;
  reg [17:0] addrIn = 18'h0;
  reg [35:0] wrData = 36'h0, expd [0:3];
  wire [35:0] dataIn, dataOut, dataOe;
  integer error_cnt = 0, num_checks = 0, i;
  localparam [17:0] A = 18'h3FFFC;
  sbsp_port i_sbsp_port (.*);
  sbsp_ctrl_model i_sbsp_ctrl_model (.*);
  task op(input [2:0] st, input [2:0] cs, input [5:0] w, input [17:0] a);
    @(posedge mclk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= st;
    {chip_sel_primary_n, chip_sel_high, chip_sel_depth_n} <= cs;
    {byte_write_qualify_n, all_bytes_write_n, byte_lane_write_sel_n} <= w;
    addrIn <= a;
  endtask
  task chk(input [35:0] s, input [35:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED pins exp %h got %h", e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #4 mclk = ~mclk;
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    chk(dataOe, 36'h0);
    for (i = 0; i < 4; i = i + 1) begin
      expd[i] = 36'h1A2B3C4D0 + i;
      op(3'h5, 3'h2, 6'h2F, A + i[17:0]);
      wrData <= expd[i];
    end
    op(3'h5, 3'h2, 6'h1D, A + 18'h1);
    wrData <= 36'hFFFFFFFFF;
    op(3'h5, 3'h2, 6'h30, A + 18'h2);
    expd[1][17:9] = 9'h1FF;
    output_en_n <= 1'b0;
    op(3'h5, 3'h6, 6'h3F, A);
    op(3'h3, 3'h2, 6'h3F, A + 18'h2);
    for (i = 0; i < 6; i = i + 1) begin
      op(3'h6, 3'h2, 6'h3F, A);
      #1;
      if (i == 0)
        chk(dataOe, 36'h0);
      else
        chk(dataOut, expd[(i + 1) % 4]);
    end
    chk(dataOe, 36'hFFFFFFFFF);
    op(3'h5, 3'h0, 6'h3F, A);
    op(3'h1, 3'h2, 6'h1E, A);
    op(3'h3, 3'h6, 6'h3F, A + 18'h1);
    op(3'h7, 3'h2, 6'h3F, A);
    op(3'h7, 3'h2, 6'h3F, A);
    #1 chk(dataOut, expd[0]);
    op(3'h5, 3'h3, 6'h3F, A);
    op(3'h3, 3'h2, 6'h3F, A);
    op(3'h3, 3'h2, 6'h3F, A);
    op(3'h7, 3'h2, 6'h3F, A);
    // mid-cycle change: direction must follow without a clock
    #3 output_en_n = 1'b1;
    #1 chk(dataOe, 36'h0);
    wrap_up;
  end
  initial begin
    repeat (500) @(posedge mclk);
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule
